// >>> core/rtc_trim_defs.vh
`ifndef RTC_TRIM_DEFS_VH
`define RTC_TRIM_DEFS_VH

// timing
`define CLK_MHZ         16'h0028
`define HALT_TIME_US    16'h0064
`define HALT_CYC        (`HALT_TIME_US * `CLK_MHZ)

// crystal nominal pulses per second
`define XTAL_A_HZ       17'h0_8000
`define XTAL_B_HZ       17'h0_7D00
`define TRIM_LAST_SEC   5'h13

// register byte addresses
`define A_CTRL1         8'h00
`define A_CTRL2         8'h04
`define A_TRIM          8'h08
`define A_IRQ_STAT      8'h0C
`define A_IRQ_CLR       8'h10
`define A_IRQ_EN        8'h14
`define A_TIME          8'h18

// control 1 field positions
`define C1_PSEL_LO      0
`define C1_PSEL_HI      2
`define C1_TEST         3
`define C1_CLKDIS       4
`define C1_XSEL         5
`define C1_ALM2         6
`define C1_ALM1         7
`define C1_HFMT         8
`define C1_W            9

// control 2 field positions
`define C2_HALT         0

// interrupt bits
`define IRQ_HALT        0
`define IRQ_SEC         1
`define IRQ_W           2

// reset values
`define CTRL1_RST       9'h000
`define TRIM_RST        7'h00
`define IRQ_RST         2'h0
`define HALT_RST        1'b1

`endif

// >>> core/rtc_time_trim.v
// What this block does
// - trim one second in every twenty
// - middle five code bits zero: no trim
// - code is seven-bit two's complement
// - positive codes lengthen second, slowing time
// - negative codes shorten second, speeding time
// - clock output is raw, untrimmed crystal
// - halt flag set: clock output driven
// - stopped crystal sets halt flag
// - halt flag forces control 1 and trim bits zero
// - power-up sets halt flag
// - halt flag stays until host clears
`timescale 1ns/1ps
`include "rtc_trim_defs.vh"

module rtc_time_trim #(
    parameter [15:0] HALT_CYC = `HALT_CYC
) (
    input  wire        clock_i,            // 40 MHz system clock
    input  wire        rst_i,              // sync reset, power-on
    input  wire        psel_i,             // apb select
    input  wire        penable_i,          // apb enable
    input  wire        pwrite_i,           // apb write
    input  wire [7:0]  paddr_i,            // apb byte address
    input  wire [31:0] pwdata_i,           // apb write data
    input  wire        crystal_in_i,       // crystal level
    output reg  [31:0] prdata_o,           // apb read data
    output reg         pready_o,           // apb ready
    output reg         pslverr_o,          // apb error
    output reg         crystal_out_o,      // inverted crystal drive
    output reg         low_freq_clk_out_o, // raw crystal clock
    output reg         low_freq_clk_oe_o,  // clock output enable
    output reg         sec_tick_o,         // trimmed second pulse
    output reg         irq_o               // level interrupt
);

    localparam [15:0] HALT_LAST = HALT_CYC - 16'h0001;

    // second length for the given code
    function [16:0] sec_len;
        input [6:0] code;
        input       xsel_n;
        input       trim_sec;
        reg   [16:0] base;
        reg   [6:0]  mag;
        begin
            base = xsel_n ? `XTAL_B_HZ : `XTAL_A_HZ;
            mag  = 7'h00 - code;
            if (!trim_sec) begin
                sec_len = base;
            end else if (code[5:1] == 5'h00) begin
                sec_len = base;
            end else if (!code[6]) begin
                sec_len = base + {10'h000, code[5:0], 1'b0} - 17'h0_0002;
            end else begin
                sec_len = base - {9'h000, mag, 1'b0};
            end
        end
    endfunction

    // register address check
    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    reg                xin_reg;
    reg                xin_d_reg;
    reg  [15:0]        idle_reg;
    reg                halted_reg;
    reg                halt_flag_reg;
    reg  [`C1_W-1:0]   ctrl1_reg;
    reg  [6:0]         trim_reg;
    reg  [`IRQ_W-1:0]  stat_reg;
    reg  [`IRQ_W-1:0]  en_reg;
    reg  [16:0]        sub_reg;
    reg  [4:0]         sec_idx_reg;
    reg  [31:0]        rd_next;
    reg                err_next;
    reg  [`IRQ_W-1:0]  stat_next;
    reg                halt_flag_next;

    wire osc_tick;
    wire halt_evt;
    wire wr_acc;
    wire setup;
    wire sec_end;
    wire [16:0] cur_len;
    wire [`IRQ_W-1:0] evt;
    wire [`IRQ_W-1:0] clr;

    assign osc_tick = xin_reg & ~xin_d_reg;
    assign setup    = psel_i & ~penable_i;
    assign wr_acc   = psel_i & penable_i & pready_o & pwrite_i;

    assign halt_evt = ~halted_reg & ~osc_tick & (idle_reg == HALT_LAST);

    assign cur_len = sec_len(trim_reg, ctrl1_reg[`C1_XSEL],
                             sec_idx_reg == `TRIM_LAST_SEC);
    assign sec_end = osc_tick & (sub_reg == cur_len - 17'h0_0001);

    assign evt[`IRQ_HALT] = halt_evt;
    assign evt[`IRQ_SEC]  = sec_end;
    assign clr = (wr_acc && is_addr(paddr_i, `A_IRQ_CLR))
               ? pwdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

    // crystal sampling and edge detect
    always @(posedge clock_i) begin
        if (rst_i) begin
            xin_reg   <= 1'b0;
            xin_d_reg <= 1'b0;
        end else begin
            xin_reg   <= crystal_in_i;
            xin_d_reg <= xin_reg;
        end
    end

    // oscillator watchdog; a timeout well above one crystal period
    // avoids false halts from jitter, at the cost of slower detection
    always @(posedge clock_i) begin
        if (rst_i) begin
            idle_reg   <= 16'h0000;
            halted_reg <= 1'b0;
        end else if (osc_tick) begin
            idle_reg   <= 16'h0000;
            halted_reg <= 1'b0;
        end else if (idle_reg == HALT_LAST) begin
            halted_reg <= 1'b1;
        end else begin
            idle_reg   <= idle_reg + 16'h0001;
        end
    end

    always @* begin
        halt_flag_next = halt_flag_reg;
        if (wr_acc && is_addr(paddr_i, `A_CTRL2) && !pwdata_i[`C2_HALT]) begin
            halt_flag_next = 1'b0;
        end
        if (halt_evt || halted_reg) begin
            halt_flag_next = 1'b1;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            halt_flag_reg <= `HALT_RST;
        end else begin
            halt_flag_reg <= halt_flag_next;
        end
    end

    // configuration registers
    always @(posedge clock_i) begin
        if (rst_i) begin
            ctrl1_reg <= `CTRL1_RST;
            trim_reg  <= `TRIM_RST;
            en_reg    <= `IRQ_RST;
        end else begin
            if (wr_acc && is_addr(paddr_i, `A_CTRL1)) begin
                ctrl1_reg <= pwdata_i[`C1_W-1:0];
            end else if (wr_acc && is_addr(paddr_i, `A_TRIM)) begin
                trim_reg <= pwdata_i[6:0];
            end else if (wr_acc && is_addr(paddr_i, `A_IRQ_EN)) begin
                en_reg <= pwdata_i[`IRQ_W-1:0];
            end
            if (halt_flag_next) begin
                ctrl1_reg <= `CTRL1_RST;
                trim_reg  <= `TRIM_RST;
            end
        end
    end

    // second prescaler
    always @(posedge clock_i) begin
        if (rst_i) begin
            sub_reg     <= 17'h0_0000;
            sec_idx_reg <= 5'h00;
            sec_tick_o  <= 1'b0;
        end else begin
            sec_tick_o <= sec_end;
            if (sec_end) begin
                sub_reg <= 17'h0_0000;
                if (sec_idx_reg == `TRIM_LAST_SEC) begin
                    sec_idx_reg <= 5'h00;
                end else begin
                    sec_idx_reg <= sec_idx_reg + 5'h01;
                end
            end else if (osc_tick) begin
                sub_reg <= sub_reg + 17'h0_0001;
            end
        end
    end

    always @* begin
        stat_next = (stat_reg & ~clr) | evt;
    end

    // interrupt status; event beats clear
    always @(posedge clock_i) begin
        if (rst_i) begin
            stat_reg <= `IRQ_RST;
            irq_o    <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_o    <= |(stat_next & en_reg);
        end
    end

    // crystal pins and clock output
    always @(posedge clock_i) begin
        if (rst_i) begin
            crystal_out_o      <= 1'b1;
            low_freq_clk_out_o <= 1'b0;
            low_freq_clk_oe_o  <= 1'b1;
        end else begin
            crystal_out_o      <= ~xin_reg;
            low_freq_clk_out_o <= xin_reg;
            low_freq_clk_oe_o  <= halt_flag_next | ~ctrl1_reg[`C1_CLKDIS];
        end
    end

    // apb read decode
    always @* begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        if (is_addr(paddr_i, `A_CTRL1)) begin
            rd_next[`C1_W-1:0] = ctrl1_reg;
        end else if (is_addr(paddr_i, `A_CTRL2)) begin
            rd_next[`C2_HALT] = halt_flag_reg;
        end else if (is_addr(paddr_i, `A_TRIM)) begin
            rd_next[6:0] = trim_reg;
        end else if (is_addr(paddr_i, `A_IRQ_STAT)) begin
            rd_next[`IRQ_W-1:0] = stat_reg;
        end else if (is_addr(paddr_i, `A_IRQ_CLR)) begin
            rd_next = 32'h0000_0000;
        end else if (is_addr(paddr_i, `A_IRQ_EN)) begin
            rd_next[`IRQ_W-1:0] = en_reg;
        end else if (is_addr(paddr_i, `A_TIME)) begin
            rd_next[16:0]  = sub_reg;
            rd_next[20:16] = sec_idx_reg;
        end else begin
            err_next = 1'b1;
        end
    end

    // one wait-free access phase: answer is prepared at setup
    always @(posedge clock_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_next;
            pready_o  <= 1'b1;
            pslverr_o <= err_next;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

endmodule // rtc_time_trim

// >>> test/xtal_model.sv
`timescale 1ns/1ps
module xtal_model #(parameter int HALF = 5) (
    input  wire logic clock_i, // system clock
    input  wire logic run_i,   // crystal oscillating
    output logic      xtal_o   // crystal level
);
    int cnt = 0;
    initial xtal_o = 1'b0;
    always @(posedge clock_i) if (run_i) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) xtal_o <= !xtal_o;
    end
endmodule // xtal_model

// >>> test/trim_chk_asserts.sv
`timescale 1ns/1ps
module trim_chk #(parameter [15:0] HALT_CYC = 16'h0010) (
    input wire logic        clock_i, rst_i, psel_i, penable_i, crystal_in_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o, pslverr_o, crystal_out_o, low_freq_clk_out_o,
    input wire logic        low_freq_clk_oe_o, sec_tick_o
);
    logic [15:0] still;
    logic        last_x;
    wire         halted = still > HALT_CYC + 16'h0008;
    // margin of 8 covers the sampler latency
    always @(posedge clock_i) begin
        last_x <= crystal_in_i;
        if (rst_i || crystal_in_i != last_x) still <= 16'h0000;
        else if (still != 16'hFFFF) still <= still + 16'h0001;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ready_pulse_a: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("ready not a single access cycle");
    ready_qual_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    clk_pair_a: assert property (crystal_out_o == !low_freq_clk_out_o)
        else $error("clock output not raw crystal");
    halt_oe_a: assert property (halted |-> low_freq_clk_oe_o)
        else $error("clock output off during halt");
    halt_flag_a: assert property (halted && pready_o && paddr_i == 8'h04 |-> prdata_o[0])
        else $error("halt flag not set");
    halt_zero_a: assert property (halted && pready_o && (paddr_i == 8'h00 || paddr_i == 8'h08)
        |-> prdata_o == 32'h0)
        else $error("config not forced zero");
    power_oe_a: assert property ($fell(rst_i) |-> low_freq_clk_oe_o)
        else $error("clock output off after reset");
    bad_addr_a: assert property (pready_o && paddr_i > 8'h18 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped address accepted");
    tick_pulse_a: assert property (sec_tick_o |=> !sec_tick_o)
        else $error("second tick too long");
endmodule // trim_chk
bind rtc_time_trim trim_chk #(.HALT_CYC(HALT_CYC)) CHK (.clock_i(clock_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .crystal_in_i(crystal_in_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .crystal_out_o(crystal_out_o), .low_freq_clk_out_o(low_freq_clk_out_o),
    .low_freq_clk_oe_o(low_freq_clk_oe_o), .sec_tick_o(sec_tick_o));

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, run = 1;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, rd, v;
    logic        err;
    wire         xtal, pready_o, pslverr_o, xo, lfc, oe, tick, irq_o;
    wire [31:0]  prdata_o;
    int          fails = 0, num_checks = 0, i;
    initial forever #12.5 clock_i = ~clock_i;
    xtal_model #(.HALF(5)) PEER (.clock_i(clock_i), .run_i(run), .xtal_o(xtal));
    rtc_time_trim #(.HALT_CYC(16'h0010)) DUT (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .crystal_in_i(xtal), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .crystal_out_o(xo), .low_freq_clk_out_o(lfc),
        .low_freq_clk_oe_o(oe), .sec_tick_o(tick), .irq_o(irq_o));
    task give_verdict;
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin @(posedge clock_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) chk(1, 0);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    function automatic [31:0] ctrl1_exp(input logic flag, input logic [31:0] d);
        return flag ? 32'h0 : {23'h0, d[8:0]};
    endfunction
    initial begin
        void'($urandom(44264));
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk(8'h04, 32'h1);
        v = $urandom;
        apb(1'b1, 8'h00, v);
        apb(1'b1, 8'h08, v);
        rd_chk(8'h00, ctrl1_exp(1'b1, v));
        rd_chk(8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        rd_chk(8'h04, 32'h0);
        for (i = 0; i < 8; i++) begin
            v = (i < 4) ? {25'h0, 7'h01 << (i * 2)} ^ 32'h40 : $urandom;
            apb(1'b1, 8'h08, v);
            rd_chk(8'h08, {25'h0, v[6:0]});
            apb(1'b1, 8'h00, v);
            rd_chk(8'h00, ctrl1_exp(1'b0, v));
            repeat (2) @(posedge clock_i);
            chk(oe, !v[4]);
        end
        apb(1'b0, 8'h18, 32'h0);
        v = rd;
        repeat (100) @(posedge clock_i);
        apb(1'b0, 8'h18, 32'h0);
        chk(((rd[15:0] - v[15:0]) >= 16'h0009) && ((rd[15:0] - v[15:0]) <= 16'h000B), 1);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h10, 32'h3);
        rd_chk(8'h10, 32'h0);
        run <= 1'b0;
        repeat (60) @(posedge clock_i);
        rd_chk(8'h04, 32'h1);
        rd_chk(8'h00, 32'h0);
        chk(oe, 1);
        rd_chk(8'h0C, 32'h1);
        chk(irq_o, 0);
        apb(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge clock_i);
        chk(irq_o, 1);
        run <= 1'b1;
        repeat (40) @(posedge clock_i);
        rd_chk(8'h04, 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge clock_i);
        chk(irq_o, 0);
        apb(1'b1, 8'h04, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h40, 32'h0);
        chk(err, 1);
        give_verdict;
    end
    // generous bound: the tests need just under ten microseconds
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule // tb
